// file: hw/dbwm_pkg.sv
package dbwm_pkg;
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int ADDR_W = 6;
  localparam int DEPTH = 64;
  localparam int BEATS = 4;
  localparam logic [1:0] BEAT_FIRST = 2'h0;
  localparam logic [1:0] BEAT_LAST = 2'h3;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
  localparam logic [LANES-1:0] SEL_NONE_N = 4'hf;
  typedef enum logic [1:0] {
    DBWM_IDLE = 2'b00,
    DBWM_WAIT = 2'b01,
    DBWM_DATA = 2'b10
  } dbwm_state_t;
endpackage : dbwm_pkg

// file: hw/dbwm_lane_merge.sv
`timescale 1ns/100ps
module dbwm_lane_merge (
  input wire logic [dbwm_pkg::DATA_W-1:0] old_word,
  input wire logic [dbwm_pkg::DATA_W-1:0] new_word,
  input wire logic [dbwm_pkg::LANES-1:0] sel_n,
  input wire logic narrow_mode,
  output logic [dbwm_pkg::DATA_W-1:0] merged,
  output logic any_write
);
  import dbwm_pkg::*;
  wire logic [LANES-1:0] lane_en;
  // In the narrow organisation only lane 0 exists and its select alone counts.
  assign lane_en = narrow_mode ? {3'h0, ~sel_n[0]} : ~sel_n;
  assign any_write = |lane_en;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign merged[g*LANE_W +: LANE_W] = lane_en[g] ? new_word[g*LANE_W +: LANE_W]
                                                     : old_word[g*LANE_W +: LANE_W];
    end
  endgenerate
endmodule : dbwm_lane_merge

// file: hw/dbwm_write_array.sv
`timescale 1ns/100ps
// How it works
// - All selects low stores all 36 bits.
// - Select 0 alone stores bits 8:0.
// - Select 1 alone stores bits 17:9.
// - Select 2 alone stores bits 26:18.
// - Select 3 alone stores bits 35:27.
// - All selects high writes nothing that beat.
// - Narrow mode: select 0 gates bits 8:0.
// - Selects sampled afresh on every beat.
// - Four beats follow load by one cycle.
module dbwm_write_array (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic narrow_mode,
  input wire logic load_n,
  input wire logic write_n,
  input wire logic [dbwm_pkg::ADDR_W-1:0] addr,
  input wire logic beat_strobe,
  input wire logic [dbwm_pkg::DATA_W-1:0] wr_data,
  input wire logic lane0_write_sel_n,
  input wire logic lane1_write_sel_n,
  input wire logic lane2_write_sel_n,
  input wire logic lane3_write_sel_n,
  input wire logic [dbwm_pkg::ADDR_W-1:0] rd_addr,
  output logic [dbwm_pkg::DATA_W-1:0] rd_data,
  output logic beat_written,
  output logic burst_busy
);
  import dbwm_pkg::*;
  dbwm_state_t state_ff, nxt_state;
  logic [ADDR_W-1:0] base_ff;
  logic [1:0] beat_ff;
  logic [DATA_W-1:0] mem_ff [DEPTH];
  logic [DATA_W-1:0] rd_data_ff;
  logic beat_written_ff;
  logic burst_busy_ff;
  wire logic [LANES-1:0] sel_n;
  wire logic [ADDR_W-1:0] beat_addr;
  wire logic [DATA_W-1:0] merged;
  wire logic any_write;
  wire logic start_write;
  wire logic do_beat;
  wire logic last_beat;
  assign sel_n = {lane3_write_sel_n, lane2_write_sel_n, lane1_write_sel_n, lane0_write_sel_n};
  assign start_write = ~load_n & ~write_n;
  assign beat_addr = base_ff + ADDR_W'(beat_ff);
  // Each beat_strobe stands for one true or complement clock rise.
  assign do_beat = (state_ff == DBWM_DATA) & beat_strobe;
  assign last_beat = do_beat & (beat_ff == BEAT_LAST);
  dbwm_lane_merge u_merge (
    .old_word(mem_ff[beat_addr]),
    .new_word(wr_data),
    .sel_n(sel_n),
    .narrow_mode(narrow_mode),
    .merged(merged),
    .any_write(any_write)
  );
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      DBWM_IDLE: if (start_write) nxt_state = DBWM_WAIT;
      // One whole cycle separates address load and the first beat.
      DBWM_WAIT: if (beat_strobe) nxt_state = DBWM_DATA;
      DBWM_DATA: if (last_beat) nxt_state = DBWM_IDLE;
      default: nxt_state = DBWM_IDLE;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= DBWM_IDLE;
      base_ff <= '0;
      beat_ff <= BEAT_FIRST;
      beat_written_ff <= 1'b0;
      burst_busy_ff <= 1'b0;
      rd_data_ff <= DATA_RST;
    end else begin
      state_ff <= nxt_state;
      if ((state_ff == DBWM_IDLE) & start_write) begin
        base_ff <= addr;
        beat_ff <= BEAT_FIRST;
      end else if (do_beat) begin
        beat_ff <= beat_ff + 2'h1;
      end
      beat_written_ff <= do_beat & any_write;
      burst_busy_ff <= nxt_state != DBWM_IDLE;
      rd_data_ff <= mem_ff[rd_addr];
    end
  end
  // The array itself carries no reset, as storage contents are undefined at power-up.
  always_ff @(posedge core_clk) begin
    if (!rst & do_beat & any_write) begin
      mem_ff[beat_addr] <= merged;
    end
  end
  assign rd_data = rd_data_ff;
  assign beat_written = beat_written_ff;
  assign burst_busy = burst_busy_ff;
endmodule : dbwm_write_array

// file: testbench/dbwm_chk.sv
`timescale 1ns/100ps
module dbwm_chk (input wire logic core_clk, rst, narrow_mode, load_n, write_n, beat_strobe,
  lane0_write_sel_n, lane1_write_sel_n, lane2_write_sel_n, lane3_write_sel_n,
  beat_written, burst_busy);
  import dbwm_pkg::*;
  wire logic hi = lane0_write_sel_n & (narrow_mode | lane1_write_sel_n & lane2_write_sel_n
    & lane3_write_sel_n);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_NOWR: assert property (!beat_strobe || hi |=> !beat_written)
    else $error("write without lane");
  AST_WRCAUSE: assert property (beat_written |-> $past(burst_busy && beat_strobe && !hi))
    else $error("write without beat");
  AST_START: assert property (!burst_busy && !load_n && !write_n |=> burst_busy)
    else $error("load missed");
  AST_HOLD: assert property (burst_busy && !beat_strobe |=> burst_busy)
    else $error("burst dropped");
  AST_IDLE: assert property (!burst_busy && (load_n || write_n) |=> !burst_busy)
    else $error("busy without load");
  AST_END: assert property ($fell(burst_busy) |-> $past(beat_strobe))
    else $error("burst end without beat");
  COV_WR: cover property (beat_written);
  COV_END: cover property ($fell(burst_busy));
  COV_NARROW: cover property (narrow_mode && beat_written);
endmodule : dbwm_chk

// file: testbench/dbwm_ctl.sv
`timescale 1ns/100ps
module dbwm_ctl (input wire logic core_clk, output logic ld_n = 1, wr_n = 1, stb = 0,
  output logic [5:0] a_o = '0, output logic [35:0] d_o = '0, output logic [3:0] s_n = 4'hf);
  task automatic burst(input logic [5:0] a, input logic [35:0] d, input logic [15:0] s);
    @(posedge core_clk); ld_n <= 0; wr_n <= 0; a_o <= a;
    @(posedge core_clk); ld_n <= 1; wr_n <= 1; stb <= 1; a_o <= ~a;
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk); d_o <= d + k; s_n <= s[4*k+:4];
    end
    @(posedge core_clk); stb <= 0; d_o <= ~d_o; s_n <= 4'hf;
  endtask : burst
endmodule : dbwm_ctl

// file: testbench/test_dbwm_write_array.sv
`timescale 1ns/100ps
`define CHK(x, y) begin checked++; if ((x) !== (y)) begin error_cnt++; \
  $display("BAD %0t value mismatch", $time); end end
bind dbwm_write_array dbwm_chk u_chk (.*);
module test_dbwm_write_array;
  import dbwm_pkg::*;
  logic core_clk = 0, rst = 1, nm = 0, rq = 0, rv = 0, ld_n, wr_n, stb, bw, bb;
  logic [5:0] a_o, ra = '0;
  logic [35:0] d_o, rd, x = 36'h0_0000_001b, m [64], q [$];
  logic [3:0] s_n;
  int error_cnt = 0, checked = 0, wc = 0, bc = 0;
  dbwm_ctl u_ctl (.core_clk, .ld_n, .wr_n, .stb, .a_o, .d_o, .s_n);
  dbwm_write_array DUT (.core_clk, .rst, .narrow_mode(nm), .load_n(ld_n), .write_n(wr_n),
    .addr(a_o), .beat_strobe(stb), .wr_data(d_o), .lane0_write_sel_n(s_n[0]),
    .lane1_write_sel_n(s_n[1]), .lane2_write_sel_n(s_n[2]), .lane3_write_sel_n(s_n[3]),
    .rd_addr(ra), .rd_data(rd), .beat_written(bw), .burst_busy(bb));
  function automatic logic [35:0] lfsr(logic [35:0] v);
    return {v[34:0], v[35] ^ v[24]};
  endfunction : lfsr
  task automatic run(logic [5:0] a, logic [15:0] s);
    logic [35:0] w;
    logic [5:0] b;
    int nw;
    int c0;
    int c1;
    nw = 0;
    c0 = wc;
    c1 = bc;
    x = lfsr(x);
    u_ctl.burst(a, x, s);
    for (int k = 0; k < 4; k++) begin
      w = '0;
      b = a + 6'(k);
      for (int g = 0; g < 4; g++) if (!s[4*k+g] && (!nm || g == 0)) w[9*g+:9] = '1;
      m[b] = m[b] & ~w | (x + k) & w;
      nw += int'(w != '0);
      @(posedge core_clk); ra <= b; rq <= 1; q.push_back(m[b]);
    end
    @(posedge core_clk); rq <= 0;
    `CHK(wc - c0, nw)
    `CHK(bc - c1, BEATS + 1)
  endtask : run
  task conclude;
    $display("errors %0d checked %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  always @(posedge core_clk) rv <= rq;
  // Written beats and busy cycles are tallied away from the launching edge.
  always @(negedge core_clk) begin
    wc <= wc + int'(bw);
    bc <= bc + int'(bb);
  end
  always @(negedge core_clk) if (rv) `CHK(rd, q.pop_front())
  initial forever #2.5 core_clk = ~core_clk;
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 0;
    for (int i = 0; i < 12; i += 4) run(i, 16'h0000);
    run(0, 16'h7bde);
    run(4, 16'hff0f);
    repeat (4) begin x = lfsr(x); run(x[2:0], x[15:0]); end
    nm <= 1;
    run(8, 16'h0e1f);
    repeat (2) @(negedge core_clk);
    `CHK(q.size(), 0)
    conclude();
  end
  initial begin #5000; error_cnt++; conclude(); end
endmodule : test_dbwm_write_array
